// >>> tcu_regs.vh
// Register offsets, field positions, reset values and encodings of the timer
`ifndef TCU_REGS_VH
`define TCU_REGS_VH
// Byte offsets on the register bus
`define TCU_OFF_CTRL_A 12'h000
`define TCU_OFF_CTRL_B 12'h004
`define TCU_OFF_COUNT 12'h008
`define TCU_OFF_CMP_A 12'h00c
`define TCU_OFF_CMP_B 12'h010
`define TCU_OFF_MASK 12'h014
`define TCU_OFF_FLAG 12'h018
`define TCU_OFF_SVC 12'h01c
// Control A fields
`define TCU_CA_WGM_LO 1:0
`define TCU_CA_COMB 5:4
`define TCU_CA_COMA 7:6
// Control B fields
`define TCU_CB_CS 2:0
`define TCU_CB_WGM_HI 3
`define TCU_CB_FOCB 6
`define TCU_CB_FOCA 7
// Flag and mask bit positions
`define TCU_FLG_OVF 0
`define TCU_FLG_CMPA 1
`define TCU_FLG_CMPB 2
// Values
`define TCU_RST_BYTE 8'h00
`define TCU_BOTTOM 8'h00
`define TCU_MAX 8'hff
`define TCU_WGM_NORMAL 3'h0
`define TCU_WGM_PCPWM 3'h1
`define TCU_WGM_CTC 3'h2
`define TCU_WGM_FAST 3'h3
`define TCU_WGM_PCPWM_A 3'h5
`define TCU_WGM_FAST_A 3'h7
`define TCU_CS_STOP 3'h0
`define TCU_CS_EXT_FALL 3'h6
`define TCU_CS_EXT_RISE 3'h7
`endif

// >>> tcu_tick_gen.v
// Timer tick source: prescaler taps or external count input edges
`timescale 1ns/100ps
`include "tcu_regs.vh"
module tcu_tick_gen (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [2:0] clock_source_select_i,
  input wire external_count_input_i,
  output reg timer_tick_o
);
  reg [9:0] presc_ff;
  reg ext_meta_ff;
  reg ext_sync_ff;
  reg ext_prev_ff;
  reg nxt_tick;
  wire ext_rise;
  wire ext_fall;

  // Free-running prescaler and two-stage synchroniser on the pin
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc_ff <= 10'h000;
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
    end else begin
      presc_ff <= presc_ff + 10'h001;
      ext_meta_ff <= external_count_input_i;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= ext_sync_ff;
    end
  end

  assign ext_rise = ext_sync_ff & ~ext_prev_ff;
  assign ext_fall = ~ext_sync_ff & ext_prev_ff;

  // Select source and edge; zero selects no tick
  always @* begin
    case (clock_source_select_i)
      `TCU_CS_STOP: nxt_tick = 1'b0;
      3'h1: nxt_tick = 1'b1;
      3'h2: nxt_tick = (presc_ff[2:0] == 3'h7);
      3'h3: nxt_tick = (presc_ff[5:0] == 6'h3f);
      3'h4: nxt_tick = (presc_ff[7:0] == 8'hff);
      3'h5: nxt_tick = (presc_ff == 10'h3ff);
      `TCU_CS_EXT_FALL: nxt_tick = ext_fall;
      `TCU_CS_EXT_RISE: nxt_tick = ext_rise;
      default: nxt_tick = 1'b0;
    endcase
  end

  // Registered one-cycle tick
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_tick_o <= 1'b0;
    end else begin
      timer_tick_o <= nxt_tick;
    end
  end
endmodule // tcu_tick_gen

// >>> tcu_timer.v
// 8-bit timer/counter with two compare channels and an APB register slave
//
// Overview of operation
// - Count and compare values are 8 bits
// - Flags show requests, each gated by mask
// - Tick from prescaler or external pin edge
// - Clock select zero stops the counter
// - Each tick clears, increments or decrements
// - CPU count write beats clear or count
// - Bottom 0x00, max 0xFF, top per mode
// - Mode bits split across control A and B
// - Match sets compare flag one tick later
// - Masked flag requests interrupt, cleared when serviced
// - Writing one clears flag, zero keeps
// - Overflow flag set per mode, requests interrupt
// - Compare buffered only in PWM modes
// - Buffer copied at top only
// - CPU reaches buffer or active compare register
// - Force strobe acts on output outside PWM modes, no flag
// - Count write blocks matches next tick
// - Output from match, mode, action, extremes
// - Normal mode wraps, overflow at zero
// - Clear-on-match mode clears at compare A
// - Fast PWM top 0xFF or compare A
// - Action zero leaves output untouched
`timescale 1ns/100ps
`include "tcu_regs.vh"
module tcu_timer (
  input wire mclk_i,
  input wire rst_n_i,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire external_count_input_i,
  output reg waveform_output_a_o,
  output reg waveform_output_b_o,
  output reg ovf_irq_o,
  output reg cmpa_irq_o,
  output reg cmpb_irq_o
);
  reg [7:0] ctrl_a_ff;
  reg [3:0] ctrl_b_ff;
  reg [7:0] timer_count_value_ff;
  reg [7:0] compare_a_value_ff;
  reg [7:0] compare_b_value_ff;
  reg [7:0] buf_a_ff;
  reg [7:0] buf_b_ff;
  reg [2:0] timer_mask_register_ff;
  reg [2:0] timer_flag_register_ff;
  reg dir_down_ff;
  reg block_ff;
  reg [31:0] nxt_rdata;
  reg [7:0] nxt_count;
  reg nxt_down;
  reg nxt_wave_a;
  reg nxt_wave_b;
  reg hit_ovf;
  wire timer_tick;
  wire acc;
  wire wr;
  wire [2:0] waveform_mode_select;
  wire [1:0] act_a;
  wire [1:0] act_b;
  wire pwm_mode;
  wire fast_mode;
  wire pc_mode;
  wire [7:0] top_val;
  wire at_top;
  wire at_bottom;
  wire eq_a;
  wire eq_b;
  wire m_a;
  wire m_b;
  wire wr_ctrl_b;
  wire wr_count;
  wire force_a;
  wire force_b;
  wire [2:0] clr_sw;
  wire [2:0] clr_svc;
  wire [2:0] set_flags;
  wire [2:0] nxt_flags;
  wire wr_ctrl_a;
  wire wr_mask;
  wire wr_flag;
  wire wr_svc;
  wire wr_cmp_a;
  wire wr_cmp_b;
  wire tick_m_a;
  wire tick_m_b;
  wire load_buf;

  tcu_tick_gen u_tick (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .clock_source_select_i(ctrl_b_ff[`TCU_CB_CS]),
    .external_count_input_i(external_count_input_i),
    .timer_tick_o(timer_tick)
  );

  // Bus decode; zero-wait slave
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign wr_ctrl_b = wr & (paddr == `TCU_OFF_CTRL_B);
  assign wr_count = wr & (paddr == `TCU_OFF_COUNT);
  assign force_a = wr_ctrl_b & pwdata[`TCU_CB_FOCA] & ~pwm_mode;
  assign force_b = wr_ctrl_b & pwdata[`TCU_CB_FOCB] & ~pwm_mode;

  // Write strobes of the remaining registers
  assign wr_ctrl_a = wr & (paddr == `TCU_OFF_CTRL_A);
  assign wr_mask = wr & (paddr == `TCU_OFF_MASK);
  assign wr_flag = wr & (paddr == `TCU_OFF_FLAG);
  assign wr_svc = wr & (paddr == `TCU_OFF_SVC);
  assign wr_cmp_a = wr & (paddr == `TCU_OFF_CMP_A);
  assign wr_cmp_b = wr & (paddr == `TCU_OFF_CMP_B);

  // Mode decode from split fields
  assign waveform_mode_select = {ctrl_b_ff[3],
    ctrl_a_ff[`TCU_CA_WGM_LO]};
  assign act_a = ctrl_a_ff[`TCU_CA_COMA];
  assign act_b = ctrl_a_ff[`TCU_CA_COMB];
  assign fast_mode = (waveform_mode_select == `TCU_WGM_FAST) |
    (waveform_mode_select == `TCU_WGM_FAST_A);
  assign pc_mode = (waveform_mode_select == `TCU_WGM_PCPWM) |
    (waveform_mode_select == `TCU_WGM_PCPWM_A);
  assign pwm_mode = fast_mode | pc_mode;
  assign top_val = waveform_mode_select[2] ? compare_a_value_ff :
    `TCU_MAX;
  assign at_top = (timer_count_value_ff == top_val);
  assign at_bottom = (timer_count_value_ff == `TCU_BOTTOM);

  // Comparators run always; matches blocked after a count write
  assign eq_a = (timer_count_value_ff == compare_a_value_ff);
  assign eq_b = (timer_count_value_ff == compare_b_value_ff);
  assign m_a = eq_a & ~block_ff;
  assign m_b = eq_b & ~block_ff;

  // Matches that land on a tick; buffer load at top of a PWM cycle
  assign tick_m_a = timer_tick & m_a;
  assign tick_m_b = timer_tick & m_b;
  assign load_buf = pwm_mode & timer_tick & at_top;

  // Next count and direction per mode
  always @* begin
    nxt_count = timer_count_value_ff;
    nxt_down = dir_down_ff;
    hit_ovf = 1'b0;
    case (waveform_mode_select)
      `TCU_WGM_CTC: begin
        if (eq_a) begin
          nxt_count = `TCU_BOTTOM;
        end else begin
          nxt_count = timer_count_value_ff + 8'h01;
        end
        hit_ovf = (timer_count_value_ff == `TCU_MAX) & ~eq_a;
      end
      `TCU_WGM_FAST, `TCU_WGM_FAST_A: begin
        if (at_top) begin
          nxt_count = `TCU_BOTTOM;
        end else begin
          nxt_count = timer_count_value_ff + 8'h01;
        end
        hit_ovf = at_top;
      end
      `TCU_WGM_PCPWM, `TCU_WGM_PCPWM_A: begin
        if (at_top) begin
          nxt_down = 1'b1;
        end else if (at_bottom) begin
          nxt_down = 1'b0;
        end
        if (nxt_down) begin
          nxt_count = timer_count_value_ff - 8'h01;
        end else begin
          nxt_count = timer_count_value_ff + 8'h01;
        end
        hit_ovf = at_bottom;
      end
      default: begin
        nxt_count = timer_count_value_ff + 8'h01;
        hit_ovf = (timer_count_value_ff == `TCU_MAX);
      end
    endcase
  end

  // Waveform generator for both channels
  always @* begin
    nxt_wave_a = waveform_output_a_o;
    nxt_wave_b = waveform_output_b_o;
    if (pwm_mode) begin
      // extreme values handled via top in fast PWM only; bottom is not used
      if (fast_mode & at_top & act_a[1]) begin
        nxt_wave_a = ~act_a[0];
      end else if (m_a & act_a[1]) begin
        nxt_wave_a = act_a[0] ^ (pc_mode & dir_down_ff);
      end
      if (fast_mode & at_top & act_b[1]) begin
        nxt_wave_b = ~act_b[0];
      end else if (m_b & act_b[1]) begin
        nxt_wave_b = act_b[0] ^ (pc_mode & dir_down_ff);
      end
    end else begin
      // set, clear or toggle on match; zero does nothing
      if (tick_m_a | force_a) begin
        case (act_a)
          2'h1: nxt_wave_a = ~waveform_output_a_o;
          2'h2: nxt_wave_a = 1'b0;
          2'h3: nxt_wave_a = 1'b1;
          default: nxt_wave_a = waveform_output_a_o;
        endcase
      end
      if (tick_m_b | force_b) begin
        case (act_b)
          2'h1: nxt_wave_b = ~waveform_output_b_o;
          2'h2: nxt_wave_b = 1'b0;
          2'h3: nxt_wave_b = 1'b1;
          default: nxt_wave_b = waveform_output_b_o;
        endcase
      end
    end
  end

  // Flag set and clear terms
  assign set_flags = {tick_m_b, tick_m_a, timer_tick & hit_ovf};
  assign clr_sw = wr_flag ? pwdata[2:0] : 3'h0;
  assign clr_svc = wr_svc ? pwdata[2:0] : 3'h0;
  assign nxt_flags = (timer_flag_register_ff & ~(clr_sw | clr_svc)) |
    set_flags;

  // Register file, counter, compare and flags
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_a_ff <= `TCU_RST_BYTE;
      ctrl_b_ff <= 4'h0;
      timer_count_value_ff <= `TCU_RST_BYTE;
      compare_a_value_ff <= `TCU_RST_BYTE;
      compare_b_value_ff <= `TCU_RST_BYTE;
      buf_a_ff <= `TCU_RST_BYTE;
      buf_b_ff <= `TCU_RST_BYTE;
      timer_mask_register_ff <= 3'h0;
      timer_flag_register_ff <= 3'h0;
      dir_down_ff <= 1'b0;
      block_ff <= 1'b0;
    end else begin
      // Control and mask writes
      if (wr_ctrl_a) begin
        ctrl_a_ff <= pwdata[7:0];
      end
      if (wr_ctrl_b) begin
        ctrl_b_ff <= {pwdata[`TCU_CB_WGM_HI], pwdata[`TCU_CB_CS]};
      end
      if (wr_mask) begin
        timer_mask_register_ff <= pwdata[2:0];
      end
      // Count write wins; block lasts until the next tick passes
      if (wr_count) begin
        timer_count_value_ff <= pwdata[7:0];
        block_ff <= 1'b1;
      end else begin
        if (timer_tick) begin
          timer_count_value_ff <= nxt_count;
          dir_down_ff <= nxt_down;
          block_ff <= 1'b0;
        end
      end
      // Compare writes go to buffer or active register
      if (wr_cmp_a) begin
        if (pwm_mode) begin
          buf_a_ff <= pwdata[7:0];
        end else begin
          compare_a_value_ff <= pwdata[7:0];
          buf_a_ff <= pwdata[7:0];
        end
      end else if (load_buf) begin
        compare_a_value_ff <= buf_a_ff;
      end
      if (wr_cmp_b) begin
        if (pwm_mode) begin
          buf_b_ff <= pwdata[7:0];
        end else begin
          compare_b_value_ff <= pwdata[7:0];
          buf_b_ff <= pwdata[7:0];
        end
      end else if (load_buf) begin
        compare_b_value_ff <= buf_b_ff;
      end
      // Set wins over a clear in the same cycle
      timer_flag_register_ff <= nxt_flags;
    end
  end

  // Read mux
  always @* begin
    case (paddr)
      `TCU_OFF_CTRL_A: nxt_rdata = {24'h000000, ctrl_a_ff};
      `TCU_OFF_CTRL_B: nxt_rdata = {28'h0000000, ctrl_b_ff};
      `TCU_OFF_COUNT: nxt_rdata = {24'h000000, timer_count_value_ff};
      `TCU_OFF_CMP_A: nxt_rdata = {24'h000000,
        (pwm_mode ? buf_a_ff : compare_a_value_ff)};
      `TCU_OFF_CMP_B: nxt_rdata = {24'h000000,
        (pwm_mode ? buf_b_ff : compare_b_value_ff)};
      `TCU_OFF_MASK: nxt_rdata = {29'h00000000, timer_mask_register_ff};
      `TCU_OFF_FLAG: nxt_rdata = {29'h00000000, timer_flag_register_ff};
      `TCU_OFF_SVC: nxt_rdata = 32'h00000000;
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  // Registered outputs: bus answer, waveforms, requests
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      waveform_output_a_o <= 1'b0;
      waveform_output_b_o <= 1'b0;
      ovf_irq_o <= 1'b0;
      cmpa_irq_o <= 1'b0;
      cmpb_irq_o <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > `TCU_OFF_SVC |
        paddr[1:0] != 2'h0);
      prdata <= nxt_rdata;
      // Waveforms move only on a tick or a force strobe
      if (timer_tick | force_a | force_b) begin
        waveform_output_a_o <= nxt_wave_a;
        waveform_output_b_o <= nxt_wave_b;
      end
      // Requests follow flag and mask one cycle later
      ovf_irq_o <= timer_flag_register_ff[`TCU_FLG_OVF] &
        timer_mask_register_ff[`TCU_FLG_OVF];
      cmpa_irq_o <= timer_flag_register_ff[`TCU_FLG_CMPA] &
        timer_mask_register_ff[`TCU_FLG_CMPA];
      cmpb_irq_o <= timer_flag_register_ff[`TCU_FLG_CMPB] &
        timer_mask_register_ff[`TCU_FLG_CMPB];
    end
  end
endmodule // tcu_timer

// >>> tcu_pin_model.sv
// Far-side pin model: drives edges onto the external count input
`timescale 1ns/100ps
module tcu_pin_model (
  input wire mclk_i,
  input wire go_i,
  input wire slow_i,
  input wire [3:0] count_i,
  output logic ext_o,
  output logic busy_o
);
  int len;
  initial begin
    ext_o = 1'b0;
    busy_o = 1'b0;
  end
  // Whole pulses only; the pin idles low between bursts
  always @(posedge mclk_i) begin
    if (go_i) begin
      len = slow_i ? 12 : 4;
      busy_o <= 1'b1;
      for (int i = 0; i < count_i; i++) begin
        ext_o <= 1'b1;
        repeat (len) @(posedge mclk_i);
        ext_o <= 1'b0;
        repeat (len) @(posedge mclk_i);
      end
      busy_o <= 1'b0;
    end
  end
endmodule // tcu_pin_model

// >>> tcu_timer_chk.sv
// Port checker for the timer register slave and outputs
`timescale 1ns/100ps
module tcu_timer_chk (
  input wire mclk_i,
  input wire rst_n_i,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire waveform_output_a_o,
  input wire waveform_output_b_o,
  input wire ovf_irq_o,
  input wire cmpa_irq_o,
  input wire cmpb_irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Bus answers, errors and read data shape
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_idle_a: assert property (!psel |=> !pready)
    else $error("ready without request");
  err_unmapped_a: assert property (psel && !penable &&
    (paddr > 12'h01c || paddr[1:0] != 2'h0) |=> pslverr)
    else $error("unmapped access not refused");
  err_mapped_a: assert property (psel && !penable &&
    paddr <= 12'h01c && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  err_reads_zero_a: assert property (pready && pslverr && !pwrite
    |-> prdata == 32'h0)
    else $error("refused read not zero");
  reset_quiet_a: assert property ($rose(rst_n_i) |-> !pready &&
    !ovf_irq_o && !cmpa_irq_o && !cmpb_irq_o &&
    !waveform_output_a_o && !waveform_output_b_o)
    else $error("outputs active after reset");
  // Main scenarios reached
  cover property (psel && penable && pready && pwrite);
  cover property (pslverr);
  cover property ($rose(ovf_irq_o));
  cover property ($rose(waveform_output_a_o));
endmodule // tcu_timer_chk
bind tcu_timer tcu_timer_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .waveform_output_a_o(waveform_output_a_o),
  .waveform_output_b_o(waveform_output_b_o), .ovf_irq_o(ovf_irq_o),
  .cmpa_irq_o(cmpa_irq_o), .cmpb_irq_o(cmpb_irq_o));

// >>> timer_counter_compare_unit_test.sv
// Self-checking bench for the timer with APB master and pin model
`timescale 1ns/100ps
`include "tcu_regs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module timer_counter_compare_unit_test;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, go = 1'b0, slow = 1'b0, ext, pbusy;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, wa, wb, iov, ia, ib;
  logic [3:0] npulse = 4'h0;
  logic [32:0] q[$];
  logic [32:0] exp_rd;
  logic [7:0] r;
  int err_count = 0, n_tests = 0;
  always #20 mclk_i = ~mclk_i;
  tcu_timer dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_input_i(ext), .waveform_output_a_o(wa),
    .waveform_output_b_o(wb), .ovf_irq_o(iov), .cmpa_irq_o(ia),
    .cmpb_irq_o(ib));
  tcu_pin_model pm (.mclk_i(mclk_i), .go_i(go), .slow_i(slow),
    .count_i(npulse), .ext_o(ext), .busy_o(pbusy));
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [7:0] d);
    @(posedge mclk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w;
    paddr <= a; pwdata <= {24'h0, d};
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  // Expected read answer is noted before the read goes out
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(1'b0, a, 8'h0);
  endtask
  task automatic pulses(input logic s, input logic [3:0] n);
    @(posedge mclk_i);
    slow <= s; npulse <= n; go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    repeat (2) @(posedge mclk_i);
    while (pbusy) @(posedge mclk_i);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Read monitor: oldest note against each completed read
  always @(posedge mclk_i) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      exp_rd = q.pop_front();
      `CHK({pslverr, prdata}, exp_rd)
    end
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    test_done;
  end
  // Main sequence
  initial begin
    void'($urandom(25895));
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(`TCU_OFF_COUNT, 33'h0);
    rd(12'h020, {1'b1, 32'h0});
    rd(12'h00d, {1'b1, 32'h0});
    r = 8'($urandom);
    wr(`TCU_OFF_COUNT, r);
    repeat (20) @(posedge mclk_i);
    rd(`TCU_OFF_COUNT, {25'h0, r});
    wr(`TCU_OFF_COUNT, 8'h00);
    wr(`TCU_OFF_CTRL_B, `TCU_CS_EXT_RISE);
    pulses(1'b0, 4'h3);
    pulses(1'b1, 4'h2);
    repeat (8) @(posedge mclk_i);
    wr(`TCU_OFF_CTRL_B, 8'h00);
    rd(`TCU_OFF_COUNT, 33'h5);
    wr(`TCU_OFF_FLAG, 8'h07);
    wr(`TCU_OFF_MASK, 8'h07);
    wr(`TCU_OFF_COUNT, 8'hfd);
    wr(`TCU_OFF_CTRL_B, 8'h01);
    repeat (10) @(posedge mclk_i);
    wr(`TCU_OFF_CTRL_B, 8'h00);
    rd(`TCU_OFF_FLAG, 33'h7);
    `CHK({ib, ia, iov}, 3'h7)
    wr(`TCU_OFF_FLAG, 8'h02);
    wr(`TCU_OFF_SVC, 8'h01);
    rd(`TCU_OFF_FLAG, 33'h4);
    `CHK({ib, ia, iov}, 3'h4)
    wr(`TCU_OFF_MASK, 8'h00);
    repeat (2) @(posedge mclk_i);
    `CHK({ib, ia, iov}, 3'h0)
    wr(`TCU_OFF_FLAG, 8'h07);
    wr(`TCU_OFF_CTRL_A, `TCU_WGM_CTC);
    wr(`TCU_OFF_CMP_A, 8'hf0);
    wr(`TCU_OFF_CMP_B, 8'h80);
    wr(`TCU_OFF_COUNT, 8'he0);
    wr(`TCU_OFF_CTRL_B, 8'h01);
    repeat (60) @(posedge mclk_i);
    wr(`TCU_OFF_CTRL_B, 8'h00);
    rd(`TCU_OFF_FLAG, 33'h2);
    wr(`TCU_OFF_FLAG, 8'h07);
    wr(`TCU_OFF_CTRL_A, 8'h40);
    wr(`TCU_OFF_CTRL_B, 8'hc0);
    repeat (3) @(posedge mclk_i);
    `CHK(wa, 1'b1)
    `CHK(wb, 1'b0)
    rd(`TCU_OFF_FLAG, 33'h0);
    wr(`TCU_OFF_CMP_A, 8'h30);
    wr(`TCU_OFF_COUNT, 8'h30);
    wr(`TCU_OFF_CTRL_B, 8'h01);
    repeat (2) @(posedge mclk_i);
    wr(`TCU_OFF_CTRL_B, 8'h00);
    rd(`TCU_OFF_FLAG, 33'h0);
    // Fast PWM, top from compare A, new top loaded from buffer at top
    wr(`TCU_OFF_CTRL_A, 8'ha3);
    wr(`TCU_OFF_CMP_A, 8'h10);
    wr(`TCU_OFF_COUNT, 8'h00);
    wr(`TCU_OFF_CTRL_B, 8'h09);
    repeat (68) @(posedge mclk_i);
    wr(`TCU_OFF_CTRL_B, 8'h08);
    rd(`TCU_OFF_COUNT, 33'h5);
    rd(`TCU_OFF_FLAG, 33'h3);
    `CHK({wa, wb}, 2'h3)
    // Reset in mid-run clears outputs and control
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    `CHK({wa, wb, iov}, 3'h0)
    rst_n_i <= 1'b1;
    rd(`TCU_OFF_CTRL_B, 33'h0);
    // Phase-correct PWM turns down at top
    wr(`TCU_OFF_CTRL_A, `TCU_WGM_PCPWM);
    wr(`TCU_OFF_COUNT, 8'hfc);
    wr(`TCU_OFF_CTRL_B, 8'h01);
    repeat (2) @(posedge mclk_i);
    wr(`TCU_OFF_CTRL_B, 8'h00);
    rd(`TCU_OFF_COUNT, 33'hfd);
    repeat (4) @(posedge mclk_i);
    test_done;
  end
endmodule // timer_counter_compare_unit_test
